// ==== logic/sfp_flash_core.sv ====
// serial flash core: link shifter, command check and page rewrite engine
`timescale 1ns/1ps

// Function
// - serial input bits are captured on the rising link clock edge
// - serial output changes only after a falling link clock edge, one bit each
// - select high deselects and floats the output; select low makes it active
// - after deselect stay active until any internal cycle finishes
// - no command but a status read is accepted before a falling select edge after reset
// - reset high holds the logic in reset with the output floating
// - reset during an internal cycle aborts it; page data may be lost
// - write protect low makes the first 256 pages read-only
// - write protect high treats the lowest pages like all others
// - array is 8 sectors of 256 pages of 256 bytes
// - program only clears bits, erase sets them, write sets either value
// - sector n spans n times 0x10000 up to plus 0xFFFF
// - page write is an erase of the page followed by a program
// - one page write or program takes up to 256 bytes in one page
// - data bytes go to the page buffer from the low address byte offset
// - raising select ends the sequence and starts the internal cycle
// - on a page write, bytes not sent are filled from the current page contents; a program fills them with 0xFF
// - after the merge a page write erases the page, then programs it from the buffer; a program skips the erase
// - commands, addresses and data move msb first
// - modifying commands not ending on a byte boundary are rejected
// - modifying needs the unlock latch; it clears when the cycle completes
module sfp_flash_core #(
  parameter logic [15:0] ERASE_WAIT = sfp_pkg::ERASE_WAIT_CYC,
  parameter logic [15:0] PROG_WAIT  = sfp_pkg::PROG_WAIT_CYC
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       sclk_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       serial_in_i,
  input  wire logic                       wp_n_i,
  input  wire logic [sfp_pkg::ADDR_W-1:0] rd_addr_i,
  output logic                            serial_out_o,
  output logic                            serial_out_oe_o,
  output logic                            active_o,
  output logic                            busy_o,
  output logic                            modify_unlock_latch_o,
  output logic      [7:0]                 rd_data_o
);
  import sfp_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_MERGE = 4'b0010,
    ST_ERASE = 4'b0100,
    ST_PROG  = 4'b1000
  } sfp_state_t;

  function automatic logic is_load(input logic [7:0] op);
    is_load = (op == CMD_REWRITE) || (op == CMD_BITCLEAR);
  endfunction

  function automatic logic is_modify(input logic [7:0] op);
    is_modify = is_load(op) || (op == CMD_PAGE_ERASE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shifting in on the rising edge

  logic       frame_off;
  logic       first_q;
  logic [2:0] bit_q;
  logic [2:0] byte_q;
  logic [6:0] sh_q;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [7:0] off_q;
  logic       tog_q;
  sfp_state_t state_q;
  logic [OFF_W-1:0] idx_q;
  logic       busy_lm_q, busy_ls_q, wel_lm_q, wel_ls_q;
  logic [2:0] bit_now, byte_now;
  logic [7:0] byte_in;
  logic       byte_done, buf_wr, buf_clear;
  logic [7:0] buf_data;
  logic       buf_valid;

  // select high or reset rearms the frame start without a link edge
  assign frame_off = reset_i | cs_n_i;
  assign bit_now   = first_q ? 3'h0 : bit_q;
  assign byte_now  = first_q ? 3'h0 : byte_q;
  assign byte_in   = {sh_q, serial_in_i};
  assign byte_done = (bit_now == 3'h7);
  // buffer is frozen while the core may still be reading it
  assign buf_clear = byte_done && (byte_now == 3'h0) && is_load(byte_in) && !busy_ls_q;
  assign buf_wr    = byte_done && (byte_now >= HDR_BYTES) && is_load(opcode_q) && !busy_ls_q;

  always_ff @(posedge sclk_i or posedge frame_off) begin
    if (frame_off) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_q  <= 3'h0;
      byte_q <= 3'h0;
      sh_q   <= 7'h00;
      tog_q  <= 1'b0;
    end else begin
      bit_q <= bit_now + 3'h1;
      sh_q  <= byte_in[6:0];
      if (byte_done && (byte_now != BYTES_SAT)) begin
        byte_q <= byte_now + 3'h1;
      end else begin
        byte_q <= byte_now;
      end
      if (first_q) begin
        tog_q <= ~tog_q;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      opcode_q <= 8'h00;
      addr_q   <= 24'h000000;
      off_q    <= 8'h00;
    end else if (byte_done) begin
      if (byte_now == 3'h0) begin
        opcode_q <= byte_in;
      end
      if ((byte_now != 3'h0) && (byte_now < HDR_BYTES)) begin
        addr_q <= {addr_q[15:0], byte_in};
      end
      if (byte_now == 3'h3) begin
        off_q <= byte_in;
      end else if (buf_wr) begin
        off_q <= off_q + 8'h01;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_lm_q <= 1'b0;
      busy_ls_q <= 1'b0;
      wel_lm_q  <= 1'b0;
      wel_ls_q  <= 1'b0;
    end else begin
      busy_lm_q <= busy_o;
      busy_ls_q <= busy_lm_q;
      wel_lm_q  <= modify_unlock_latch_o;
      wel_ls_q  <= wel_lm_q;
    end
  end

  sfp_page_buf u_page_buf (
    .clk_i     (sclk_i),
    .rst_i     (reset_i),
    .clear_i   (buf_clear),
    .wr_i      (buf_wr),
    .wr_off_i  (off_q),
    .wr_data_i (byte_in),
    .rd_off_i  (idx_q),
    .rd_data_o (buf_data),
    .rd_valid_o(buf_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link domain: status shifted out on the falling edge

  logic [7:0] osh_q;
  logic [7:0] stat;

  always_comb begin
    stat = 8'h00;
    stat[STAT_BUSY_BIT] = busy_ls_q;
    stat[STAT_WEL_BIT]  = wel_ls_q;
  end

  // status repeats every byte for as long as the host keeps clocking
  always_ff @(negedge sclk_i or posedge frame_off) begin
    if (frame_off) begin
      osh_q           <= 8'h00;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else if (!first_q && (opcode_q == CMD_STATUS) && (byte_q != 3'h0)) begin
      serial_out_oe_o <= 1'b1;
      if (bit_q == 3'h0) begin
        serial_out_o <= stat[7];
        osh_q        <= {stat[6:0], 1'b0};
      end else begin
        serial_out_o <= osh_q[7];
        osh_q        <= {osh_q[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain: pin synchronisers and frame end

  logic cs_m_q, cs_s_q, cs_p_q;
  logic wp_m_q, wp_s_q;
  logic tog_m_q, tog_s_q, seen_q;
  logic armed_q;
  logic frame_end, whole_bytes, prot, cmd_ok;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_m_q  <= 1'b0;
      cs_s_q  <= 1'b0;
      cs_p_q  <= 1'b0;
      wp_m_q  <= 1'b0;
      wp_s_q  <= 1'b0;
      tog_m_q <= 1'b0;
      tog_s_q <= 1'b0;
    end else begin
      cs_m_q  <= cs_n_i;
      cs_s_q  <= cs_m_q;
      cs_p_q  <= cs_s_q;
      wp_m_q  <= wp_n_i;
      wp_s_q  <= wp_m_q;
      tog_m_q <= tog_q;
      tog_s_q <= tog_m_q;
    end
  end

  // a select held low through reset release yields no falling edge here
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      armed_q <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      if (!cs_s_q && cs_p_q) begin
        armed_q <= 1'b1;
      end
      if (cs_s_q && !cs_p_q) begin
        seen_q <= tog_s_q;
      end
    end
  end

  // link fields are stable here: select is high so the link clock is idle
  assign frame_end   = cs_s_q && !cs_p_q && (tog_s_q != seen_q);
  assign whole_bytes = (bit_q == 3'h0);
  assign prot        = !wp_s_q && (addr_q[SECTOR_LSB+2:SECTOR_LSB] == PROT_SECTOR);
  assign cmd_ok      = frame_end && armed_q && whole_bytes && (state_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // core domain: unlock latch and rewrite engine

  logic [7:0]          kind_q;
  logic [PAGE_W-1:0]   page_q;
  logic [15:0]         wait_q;
  logic                start;
  logic [7:0]          mem_q   [0:NUM_BYTES-1];
  logic [7:0]          merge_q [0:PAGE_BYTES-1];
  logic [ADDR_W-1:0]   cur_addr;
  logic                sweep_end;

  assign start = cmd_ok && modify_unlock_latch_o && !prot && is_modify(opcode_q) &&
                 ((opcode_q == CMD_PAGE_ERASE) ? (byte_q == HDR_BYTES)
                                               : (byte_q == BYTES_SAT));
  assign cur_addr  = {page_q, idx_q};
  assign sweep_end = (idx_q == 8'hFF);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      modify_unlock_latch_o <= 1'b0;
    end else if (cmd_ok && (opcode_q == CMD_UNLOCK) && (byte_q == ONE_BYTE)) begin
      modify_unlock_latch_o <= 1'b1;
    end else if (cmd_ok && (opcode_q == CMD_LOCK) && (byte_q == ONE_BYTE)) begin
      modify_unlock_latch_o <= 1'b0;
    end else if ((state_q != ST_IDLE) && (wait_q == 16'h0000) && sweep_end &&
                 ((state_q == ST_PROG) || ((state_q == ST_ERASE) &&
                  (kind_q == CMD_PAGE_ERASE)))) begin
      modify_unlock_latch_o <= 1'b0;
    end
  end

  // reset drops the engine mid-sweep; the page is left part done
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      kind_q  <= 8'h00;
      page_q  <= '0;
      idx_q   <= 8'h00;
      wait_q  <= 16'h0000;
      busy_o  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          idx_q <= 8'h00;
          if (start) begin
            kind_q  <= opcode_q;
            page_q  <= addr_q[PAGE_LSB+PAGE_W-1:PAGE_LSB];
            busy_o  <= 1'b1;
            wait_q  <= ERASE_WAIT;
            state_q <= (opcode_q == CMD_PAGE_ERASE) ? ST_ERASE : ST_MERGE;
          end
        end
        ST_MERGE: begin
          idx_q <= idx_q + 8'h01;
          if (sweep_end) begin
            wait_q  <= (kind_q == CMD_REWRITE) ? ERASE_WAIT : PROG_WAIT;
            state_q <= (kind_q == CMD_REWRITE) ? ST_ERASE : ST_PROG;
          end
        end
        ST_ERASE, ST_PROG: begin
          if (wait_q != 16'h0000) begin
            wait_q <= wait_q - 16'h0001;
          end else begin
            idx_q <= idx_q + 8'h01;
            if (sweep_end) begin
              wait_q <= PROG_WAIT;
              if ((state_q == ST_ERASE) && (kind_q == CMD_REWRITE)) begin
                state_q <= ST_PROG;
              end else begin
                state_q <= ST_IDLE;
                busy_o  <= 1'b0;
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_o  <= 1'b0;
        end
      endcase
    end
  end

  // merge store is written only in the merge sweep, then read by program
  always_ff @(posedge core_clk_i) begin
    if (state_q == ST_MERGE) begin
      if (buf_valid) begin
        merge_q[idx_q] <= buf_data;
      end else if (kind_q == CMD_REWRITE) begin
        merge_q[idx_q] <= mem_q[cur_addr];
      end else begin
        merge_q[idx_q] <= ERASED_BYTE;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if ((state_q == ST_ERASE) && (wait_q == 16'h0000)) begin
      mem_q[cur_addr] <= ERASED_BYTE;
    end else if ((state_q == ST_PROG) && (wait_q == 16'h0000)) begin
      mem_q[cur_addr] <= mem_q[cur_addr] & merge_q[idx_q];
    end
  end

  always_ff @(posedge core_clk_i) begin
    rd_data_o <= mem_q[rd_addr_i];
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      active_o <= 1'b0;
    end else begin
      active_o <= !cs_s_q || (state_q != ST_IDLE) || start;
    end
  end
endmodule

// ==== logic/sfp_page_buf.sv ====
// shared constants and the link-side page buffer of the serial flash core
package sfp_pkg;
  localparam int          ADDR_W        = 19;
  localparam int          PAGE_W        = 11;
  localparam int          OFF_W         = 8;
  localparam int          PAGE_BYTES    = 256;
  localparam int          NUM_SECTORS   = 8;
  localparam int          NUM_PAGES     = 2048;
  localparam int          NUM_BYTES     = 524288;
  localparam int          SECTOR_LSB    = 16;
  localparam int          PAGE_LSB      = 8;
  localparam logic [2:0]  PROT_SECTOR   = 3'h0;
  localparam logic [7:0]  CMD_UNLOCK    = 8'h06;
  localparam logic [7:0]  CMD_LOCK      = 8'h04;
  localparam logic [7:0]  CMD_REWRITE   = 8'h0A;
  localparam logic [7:0]  CMD_BITCLEAR  = 8'h02;
  localparam logic [7:0]  CMD_PAGE_ERASE = 8'hDB;
  localparam logic [7:0]  CMD_STATUS    = 8'h05;
  localparam logic [2:0]  HDR_BYTES     = 3'h4;
  localparam logic [2:0]  BYTES_SAT     = 3'h5;
  localparam logic [2:0]  ONE_BYTE      = 3'h1;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_WEL_BIT  = 1;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [15:0] ERASE_WAIT_CYC = 16'h00C8;
  localparam logic [15:0] PROG_WAIT_CYC = 16'h0014;
endpackage

`timescale 1ns/1ps

module sfp_page_buf (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clear_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_off_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [7:0] rd_off_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o
);
  import sfp_pkg::*;

  logic [7:0]            mem_q [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] valid_q;

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem_q[wr_off_i] <= wr_data_i;
    end
  end

  // a byte sent twice keeps only its last value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= '0;
    end else if (clear_i) begin
      valid_q <= '0;
    end else if (wr_i) begin
      valid_q[wr_off_i] <= 1'b1;
    end
  end

  // read only by the core while it is busy, when no writes are let in
  assign rd_data_o  = mem_q[rd_off_i];
  assign rd_valid_o = valid_q[rd_off_i];
endmodule

// ==== testbench/sfp_flash_core_properties.sv ====
// port checker of the serial flash core and its bind
`timescale 1ns/1ps

module sfp_flash_core_properties #(
  parameter logic [15:0] ERASE_WAIT = 16'h0000,
  parameter logic [15:0] PROG_WAIT  = 16'h0000
) (
  input wire logic                       core_clk_i,
  input wire logic                       reset_i,
  input wire logic                       sclk_i,
  input wire logic                       cs_n_i,
  input wire logic                       serial_in_i,
  input wire logic                       wp_n_i,
  input wire logic [sfp_pkg::ADDR_W-1:0] rd_addr_i,
  input wire logic                       serial_out_o,
  input wire logic                       serial_out_oe_o,
  input wire logic                       active_o,
  input wire logic                       busy_o,
  input wire logic                       modify_unlock_latch_o,
  input wire logic [7:0]                 rd_data_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // length of the running internal cycle
  logic [15:0] busy_cnt_q;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_q <= 16'h0000;
    end else if (busy_o) begin
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    end else begin
      busy_cnt_q <= 16'h0000;
    end
  end

  //////////////////////////////////////////////////
  oe_off_desel_a: assert property ($rose(cs_n_i) |-> ##[1:3] !serial_out_oe_o)
    else $error("output enable left on after deselect");
  reset_quiet_a: assert property (disable iff (1'b0)
    reset_i |-> !serial_out_oe_o && !busy_o && !modify_unlock_latch_o)
    else $error("outputs not quiet in reset");
  busy_active_a: assert property (busy_o && $past(busy_o) |-> active_o)
    else $error("standby while busy");
  standby_a: assert property ((cs_n_i && !busy_o)[*8] |-> !active_o)
    else $error("active while idle and deselected");
  latch_clear_a: assert property ($fell(busy_o) |-> !modify_unlock_latch_o)
    else $error("unlock latch kept after cycle end");
  busy_latch_a: assert property ($rose(busy_o) |-> modify_unlock_latch_o)
    else $error("cycle started without unlock latch");
  busy_deselect_a: assert property ($rose(busy_o) |-> $past(cs_n_i) && $past(cs_n_i, 2))
    else $error("cycle started while selected");
  latch_deselect_a: assert property ($rose(modify_unlock_latch_o) |->
    $past(cs_n_i) && $past(cs_n_i, 2))
    else $error("latch set before frame end");
  busy_span_a: assert property ($fell(busy_o) |-> busy_cnt_q >= 16'h0100 &&
    busy_cnt_q <= 16'h0308 + ERASE_WAIT + PROG_WAIT)
    else $error("internal cycle length out of range");

  cover property ($rose(busy_o));
  cover property ($fell(busy_o) && !modify_unlock_latch_o);
  cover property ($rose(serial_out_oe_o));
endmodule

bind sfp_flash_core sfp_flash_core_properties #(
  .ERASE_WAIT(ERASE_WAIT),
  .PROG_WAIT (PROG_WAIT)
) sfp_flash_core_properties_inst (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .serial_in_i(serial_in_i), .wp_n_i(wp_n_i), .rd_addr_i(rd_addr_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .active_o(active_o),
  .busy_o(busy_o), .modify_unlock_latch_o(modify_unlock_latch_o), .rd_data_o(rd_data_o)
);

// ==== testbench/sfp_flash_core_tb_top.sv ====
// self-checking bench of the serial flash core
`timescale 1ns/1ps

module sfp_flash_core_tb_top;
  import sfp_pkg::*;
  typedef struct {
    logic [7:0]  op;
    logic [23:0] addr;
    int          n;
    logic [7:0]  d;
    logic [7:0]  chk;
    logic [7:0]  exp;
  } sfp_row_t;

  logic        core_clk;
  logic        reset;
  logic        wp_n;
  logic [18:0] rd_addr;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        serial_out;
  logic        serial_out_oe;
  logic        active;
  logic        busy;
  logic        latch;
  logic [7:0]  rd_data;
  wire         line;
  logic [7:0]  rx;
  int          err_total;
  int          comparisons;
  sfp_row_t    rows[9];

  assign line = serial_out_oe ? serial_out : 1'bz;

  sfp_flash_core #(.ERASE_WAIT(16'h0003), .PROG_WAIT(16'h0002)) sfp_flash_core_inst (
    .core_clk_i(core_clk), .reset_i(reset), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_i(mosi), .wp_n_i(wp_n), .rd_addr_i(rd_addr), .serial_out_o(serial_out),
    .serial_out_oe_o(serial_out_oe), .active_o(active), .busy_o(busy),
    .modify_unlock_latch_o(latch), .rd_data_o(rd_data));

  sfp_spi_host sfp_spi_host_inst (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(line));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input logic [7:0] op, input logic [23:0] a, input int n,
                     input logic [7:0] d);
    logic [7:0] q[$];
    q = {op, a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      q.push_back(d + 8'(i));
    end
    sfp_spi_host_inst.xfer({CMD_UNLOCK}, 0, 0, rx);
    sfp_spi_host_inst.xfer(q, 0, 0, rx);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    cmp8("cycle end", 8'h00, {7'h00, busy});
    @(negedge core_clk);
  endtask

  task automatic peek(input logic [23:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    rd_addr <= a[18:0];
    @(posedge core_clk);
    @(negedge core_clk);
    cmp8("array byte", exp, rd_data);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end

  //////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    wp_n = 1'b1;
    rd_addr = 19'h00000;
    err_total = 0;
    comparisons = 0;
    rows = '{'{8'hDB, 24'h010100, 0, 8'h00, 8'h10, 8'hFF}, '{8'h0A, 24'h010110, 2, 8'h5A, 8'h11, 8'h5B},
             '{8'h02, 24'h010111, 1, 8'hF0, 8'h11, 8'h50}, '{8'h0A, 24'h0101FF, 2, 8'h33, 8'h00, 8'h34},
             '{8'h0A, 24'h010120, 1, 8'h77, 8'h10, 8'h5A}, '{8'h0A, 24'h010111, 1, 8'hAF, 8'h11, 8'hAF},
             '{8'hDB, 24'h010100, 0, 8'h00, 8'h10, 8'hFF}, '{8'h0A, 24'h07FF05, 1, 8'hC3, 8'h05, 8'hC3},
             '{8'h0A, 24'hF80005, 1, 8'h11, 8'h05, 8'h11}};
    // select already low at release is no falling edge
    #1 sfp_spi_host_inst.cs_n_o = 1'b0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    sfp_spi_host_inst.xfer({CMD_UNLOCK}, 0, 0, rx);
    cmp8("latch unarmed", 8'h00, {7'h00, latch});
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].addr, rows[i].n, rows[i].d);
      wait_idle();
      cmp8("latch after cycle", 8'h00, {7'h00, latch});
      peek({rows[i].addr[23:8], rows[i].chk}, rows[i].exp);
    end
    run(CMD_PAGE_ERASE, 24'h010100, 0, 8'h00);
    sfp_spi_host_inst.xfer({CMD_STATUS}, 0, 1, rx);
    cmp8("status busy", 8'h03, rx);
    cmp8("output enable", 8'h00, {7'h00, serial_out_oe});
    cmp8("active", 8'h01, {7'h00, active});
    wait_idle();
    sfp_spi_host_inst.xfer({CMD_STATUS}, 0, 1, rx);
    cmp8("status idle", 8'h00, rx);
    @(posedge core_clk);
    wp_n <= 1'b0;
    run(CMD_REWRITE, 24'h000005, 1, 8'h99);
    cmp8("busy protected", 8'h00, {7'h00, busy});
    cmp8("latch kept", 8'h01, {7'h00, latch});
    peek(24'h000005, 8'h11);
    @(posedge core_clk);
    wp_n <= 1'b1;
    sfp_spi_host_inst.xfer({CMD_LOCK}, 0, 0, rx);
    cmp8("latch locked", 8'h00, {7'h00, latch});
    sfp_spi_host_inst.xfer({CMD_REWRITE, 8'h01, 8'h01, 8'h10, 8'h44}, 0, 0, rx);
    cmp8("busy unlatched", 8'h00, {7'h00, busy});
    sfp_spi_host_inst.xfer({CMD_UNLOCK}, 1, 0, rx);
    cmp8("latch odd bits", 8'h00, {7'h00, latch});
    sfp_spi_host_inst.xfer({CMD_UNLOCK}, 0, 0, rx);
    sfp_spi_host_inst.xfer({CMD_REWRITE, 8'h01, 8'h01, 8'h10, 8'h44}, 3, 0, rx);
    cmp8("busy odd bits", 8'h00, {7'h00, busy});
    peek(24'h010110, 8'hFF);
    run(CMD_REWRITE, 24'h010130, 1, 8'h66);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp8("busy in reset", 8'h00, {7'h00, busy});
    cmp8("oe in reset", 8'h00, {7'h00, serial_out_oe});
    cmp8("latch in reset", 8'h00, {7'h00, latch});
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    sfp_spi_host_inst.xfer({CMD_UNLOCK}, 0, 0, rx);
    cmp8("latch rearmed", 8'h01, {7'h00, latch});
    tally_and_finish();
  end
endmodule

// ==== testbench/sfp_spi_host.sv ====
// bus master model that drives the serial link of the flash core
`timescale 1ns/1ps

module sfp_spi_host (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // clock stands low outside frames; extra adds stray bits past the bytes
  task automatic xfer(input logic [7:0] tx[$], input int extra, input int nrx,
                      output logic [7:0] rx);
    int nb;
    logic [7:0] b;
    nb = tx.size() * 8 + extra + nrx * 8;
    rx = 8'h00;
    cs_n_o = 1'b0;
    #37;
    for (int i = 0; i < nb; i++) begin
      b = 8'h00;
      if (i / 8 < tx.size()) begin
        b = tx[i / 8];
      end
      mosi_o = b[7 - i % 8];
      #40;
      rx = {rx[6:0], miso_i};
      sclk_o = 1'b1;
      #40;
      sclk_o = 1'b0;
    end
    #40;
    cs_n_o = 1'b1;
    // released data line must not look like a held bit
    mosi_o = ~mosi_o;
    #400;
  endtask
endmodule
